// *** hw/ispc_cfg.svh ***
/*
  Constants for the in-system flash programming controller: register
  offsets, field positions, reset values, command codes and timing counts.
  Assumes the including file sits on a Wishbone bus with 32-bit data.
*/
`ifndef ISPC_CFG_SVH
`define ISPC_CFG_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is the index times four
// ----------------------------------------------------------------
`define ISPC_IDX_TIMED    8'h c7
`define ISPC_IDX_CHIPCTL  8'h 9f
`define ISPC_IDX_TRIGGER  8'h a4
`define ISPC_IDX_ADDRLO   8'h a6
`define ISPC_IDX_ADDRHI   8'h a7
`define ISPC_IDX_DATA     8'h ae
`define ISPC_IDX_CMD      8'h af

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISPC_CC_ENABLE    0
`define ISPC_CC_BOOTSEL   1
`define ISPC_CC_LDUPD     5
`define ISPC_CC_FAULT     6
`define ISPC_CC_SOFTWARE_RESET_BIT     7
`define ISPC_TRG_GO       0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ISPC_CMD_RESET    8'h30
`define ISPC_UNLOCK_1     8'haa
`define ISPC_UNLOCK_2     8'h55
`define ISPC_REG_MAIN     2'h0
`define ISPC_REG_LOADER   2'h1
`define ISPC_REG_CONFIG   2'h3
`define ISPC_OP_READ      4'h0
`define ISPC_OP_PROGRAM   4'h1
`define ISPC_OP_ERASE     4'h2
`define ISPC_PAGE_MASK    8'h7f

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ISPC_CLK_MHZ      125
`define ISPC_OSC_START_NS 200
`define ISPC_OP_TIME_NS   4000
`define ISPC_OSC_CYC  ((`ISPC_OSC_START_NS * `ISPC_CLK_MHZ + 999) / 1000)
`define ISPC_OP_CYC   ((`ISPC_OP_TIME_NS * `ISPC_CLK_MHZ + 999) / 1000)

`endif

// *** hw/ispc_pkg.sv ***
/*
  Types for the in-system flash programming controller.
  Assumes ispc_cfg.svh is compiled alongside.
*/
package ispc_pkg;

  typedef enum logic [2:0] {
    ISPC_IDLE  = 3'h0,
    ISPC_CHECK = 3'h1,
    ISPC_RUN   = 3'h2,
    ISPC_DONE  = 3'h3
  } ispc_state_t;

  typedef struct packed {
    ispc_state_t state;
    logic [1:0]  unlock;
    logic        enable;
    logic        bootNext;
    logic        bootPrev;
    logic        ldUpdate;
    logic        fault;
    logic [7:0]  addrLo;
    logic [7:0]  addrHi;
    logic [7:0]  data;
    logic [7:0]  cmd;
    logic [15:0] count;
    logic        oscOn;
    logic        ack;
    logic [31:0] rdat;
    logic        strapped;
    logic        swReset;
  } ispc_regs_t;

endpackage

// *** hw/ispc_ctrl.sv ***
/*
  In-system flash programming controller: Wishbone register slave,
  timed-access unlock, access checker and operation sequencer that holds
  the processor and drives a byte-wide flash macro port.
  Assumes a processor that stalls on cpuHold and reports which region it
  executes from; the flash macro samples its strobes on ref_clk.
*/
`timescale 1ns/1ns
`include "ispc_cfg.svh"

module ispc_ctrl #(
  parameter int          FLASH_BYTES = 16384,
  parameter int          LOADER_BASE = 16384,
  parameter int          LOADER_SIZE = 2048,
  parameter int          OP_CYCLES   = `ISPC_OP_CYC,
  parameter logic [15:0] OSC_CYCLES  = 16'(`ISPC_OSC_CYC)
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  output      logic        wb_ack_o,
  input  wire logic        bootStrap,
  input  wire logic        runFromLoader,
  input  wire logic        runIntoExternal,
  output      logic        cpuHold,
  output      logic        oscEnable,
  output      logic        softResetReq,
  output      logic [1:0]  flashRegion,
  output      logic [15:0] flashAddr,
  output      logic [7:0]  flashWdata,
  input  wire logic [7:0]  flashRdata,
  output      logic [3:0]  flashOpCode,
  output      logic        flashStrobe
);
  import ispc_pkg::*;

  ispc_regs_t r_q;
  ispc_regs_t r_d;

  logic        req;
  logic        wr;
  logic        wrByte;
  logic [7:0]  wbyte;
  logic [7:0]  idx;
  logic [15:0] addr;
  logic [1:0]  region;
  logic [3:0]  opc;
  logic        modify;
  logic        illegal;
  logic        guarded;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req    = wb_cyc_i && wb_stb_i && !r_q.ack;
  assign wr     = req && wb_we_i;
  assign wrByte = wr && wb_sel_i[0];
  assign wbyte  = wb_dat_i[7:0];
  assign idx    = wb_adr_i[9:2];
  assign addr   = {r_q.addrHi, r_q.addrLo};
  assign region = r_q.cmd[7:6];
  assign opc    = r_q.cmd[3:0];
  assign modify = (opc == `ISPC_OP_ERASE) || (opc == `ISPC_OP_PROGRAM);
  assign guarded = (r_q.unlock == 2'h2);

  // ----------------------------------------------------------------
  // Access checker
  // ----------------------------------------------------------------
  always_comb begin
    illegal = 1'b0;
    if (runIntoExternal) begin
      illegal = 1'b1;
    end
    case (region)
      `ISPC_REG_MAIN: begin
        if (32'(addr) >= FLASH_BYTES) begin
          illegal = 1'b1;
        end
        if (modify && !runFromLoader) begin
          illegal = 1'b1;
        end
      end
      `ISPC_REG_LOADER: begin
        if (32'(addr) >= LOADER_SIZE) begin
          illegal = 1'b1;
        end
        if (modify && runFromLoader) begin
          illegal = 1'b1;
        end
        if (modify && !runFromLoader && !r_q.ldUpdate) begin
          illegal = 1'b1;
        end
      end
      `ISPC_REG_CONFIG: begin
        if (!runFromLoader) begin
          illegal = 1'b1;
        end
        if (opc == `ISPC_OP_ERASE && addr != 16'h0000) begin
          illegal = 1'b1;
        end
      end
      default: begin
        illegal = 1'b1;
      end
    endcase
    if (opc == `ISPC_OP_ERASE && (addr[7:0] & `ISPC_PAGE_MASK) != 8'h00)
    begin
      illegal = 1'b1;
    end
    if (opc != `ISPC_OP_ERASE && opc != `ISPC_OP_PROGRAM &&
        opc != `ISPC_OP_READ) begin
      illegal = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.ack = req;
    r_d.swReset = 1'b0;
    if (!r_q.strapped) begin
      r_d.strapped = 1'b1;
      r_d.bootPrev = bootStrap;
      r_d.bootNext = bootStrap;
    end
    // A software reset reboots from the source chosen by the last write
    if (r_q.swReset) begin
      r_d.bootPrev = r_q.bootNext;
    end
    r_d.oscOn = r_q.enable;

    // Timed-access unlock: 0xaa then 0x55, good for one next write
    if (wr && idx == `ISPC_IDX_TIMED && wrByte) begin
      if (wbyte == `ISPC_UNLOCK_1) begin
        r_d.unlock = 2'h1;
      end else if (wbyte == `ISPC_UNLOCK_2 && r_q.unlock == 2'h1) begin
        r_d.unlock = 2'h2;
      end else begin
        r_d.unlock = 2'h0;
      end
    end else if (wr) begin
      r_d.unlock = 2'h0;
    end

    if (wrByte) begin
      case (idx)
        `ISPC_IDX_CHIPCTL: begin
          if (guarded) begin
            r_d.enable   = wbyte[`ISPC_CC_ENABLE];
            r_d.bootNext = wbyte[`ISPC_CC_BOOTSEL];
            r_d.ldUpdate = wbyte[`ISPC_CC_LDUPD];
            r_d.swReset  = wbyte[`ISPC_CC_SOFTWARE_RESET_BIT];
            if (!wbyte[`ISPC_CC_FAULT]) begin
              r_d.fault = 1'b0;
            end
          end
        end
        `ISPC_IDX_ADDRLO: r_d.addrLo = wbyte;
        `ISPC_IDX_ADDRHI: r_d.addrHi = wbyte;
        `ISPC_IDX_DATA:   r_d.data   = wbyte;
        `ISPC_IDX_CMD:    r_d.cmd    = wbyte;
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    case (r_q.state)
      ISPC_IDLE: begin
        if (wrByte && idx == `ISPC_IDX_TRIGGER && guarded &&
            wbyte[`ISPC_TRG_GO] && r_q.enable) begin
          r_d.state = ISPC_CHECK;
          r_d.count = OSC_CYCLES;
        end
      end
      ISPC_CHECK: begin
        if (r_q.count != 16'h0000) begin
          r_d.count = r_q.count - 16'h0001;
        end else if (illegal) begin
          r_d.fault = 1'b1;
          r_d.state = ISPC_DONE;
        end else begin
          r_d.count = 16'(OP_CYCLES);
          r_d.state = ISPC_RUN;
        end
      end
      ISPC_RUN: begin
        if (r_q.count != 16'h0000) begin
          r_d.count = r_q.count - 16'h0001;
        end else begin
          if (opc == `ISPC_OP_READ) begin
            r_d.data = flashRdata;
          end
          r_d.state = ISPC_DONE;
        end
      end
      ISPC_DONE: begin
        r_d.state = ISPC_IDLE;
      end
      default: begin
        r_d.state = ISPC_IDLE;
      end
    endcase

    // Read data
    case (idx)
      `ISPC_IDX_CHIPCTL: r_d.rdat = {24'h0, 1'b0, r_d.fault,
                                     r_q.ldUpdate, 3'h0, r_q.bootPrev,
                                     r_q.enable};
      `ISPC_IDX_ADDRLO:  r_d.rdat = {24'h0, r_q.addrLo};
      `ISPC_IDX_ADDRHI:  r_d.rdat = {24'h0, r_q.addrHi};
      `ISPC_IDX_DATA:    r_d.rdat = {24'h0, r_q.data};
      `ISPC_IDX_CMD:     r_d.rdat = {24'h0, r_q.cmd};
      default:           r_d.rdat = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_q <= '{state: ISPC_IDLE, cmd: `ISPC_CMD_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o     = r_q.ack;
  assign wb_dat_o     = r_q.rdat;
  assign cpuHold      = (r_q.state != ISPC_IDLE);
  assign oscEnable    = r_q.oscOn;
  assign softResetReq = r_q.swReset;
  assign flashRegion  = region;
  assign flashAddr    = addr;
  assign flashWdata   = r_q.data;
  assign flashOpCode  = opc;
  assign flashStrobe  = (r_q.state == ISPC_RUN);
endmodule

// *** test/ispc_ctrl_assertions.sv ***
/*
  Concurrent checks on the ports of ispc_ctrl, bound below.
  Assumes the short OP_CYCLES and OSC_CYCLES that the bench sets.
*/
`timescale 1ns/1ns
`include "ispc_cfg.svh"
module ispc_chk #(
  parameter int OP_CYCLES  = 4,
  parameter int OSC_CYCLES = 1
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic        cpuHold,
  input wire logic        oscEnable,
  input wire logic        flashStrobe
);
  localparam int HMAX = OP_CYCLES + OSC_CYCLES + 6;
  logic trigWr;
  assign trigWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_dat_i[0]
                  && wb_adr_i[9:2] == `ISPC_IDX_TRIGGER;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence runBurst;
    flashStrobe [*5] ##1 !flashStrobe;
  endsequence
  sequence holdRelease;
    ##[1:HMAX] !cpuHold;
  endsequence
  a_ack_reply: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_hold_cause: assert property (
    $rose(cpuHold) |-> $past(trigWr) || $past(trigWr, 2))
    else $error("processor held without a go write");
  a_hold_release: assert property (
    $rose(cpuHold) |-> holdRelease)
    else $error("processor held too long");
  a_strobe_span: assert property (
    $rose(flashStrobe) |-> runBurst)
    else $error("flash strobe length wrong");
  a_strobe_held: assert property (
    flashStrobe |-> cpuHold && oscEnable)
    else $error("strobe without hold or oscillator");
  a_osc_wait: assert property (
    $rose(flashStrobe) |-> $past(cpuHold, 2) && !$past(cpuHold, 3))
    else $error("oscillator start wait wrong");
  a_go_reads_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[9:2] == `ISPC_IDX_TRIGGER
    |-> !wb_dat_o[0])
    else $error("go bit read as one");
endmodule

bind ispc_ctrl ispc_chk #(
  .OP_CYCLES(OP_CYCLES),
  .OSC_CYCLES(OSC_CYCLES)
) chk_u (
  .ref_clk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_ack_o, .cpuHold, .oscEnable, .flashStrobe
);

// *** test/tb_ispc_ctrl.sv ***
/*
  Self-checking bench for ispc_ctrl: registers, triggering, faults.
  Assumes ispc_cfg.svh and ispc_pkg on the compile path.
*/
`timescale 1ns/1ns
`include "ispc_cfg.svh"
module tb_ispc_ctrl;
  import ispc_pkg::*;
  logic        ref_clk, rst_n, cyc, we, ack, boot, rfl, ext, hold;
  logic        osc, strobe, holdSeen, strobeSeen, l, x, le;
  logic        srst, srstSeen;
  logic [1:0]  fReg;
  logic [31:0] adr, wdat, rdat, rng, d;
  logic [15:0] fAddr, a;
  logic [7:0]  rdIn, wdOut, wdSeen, c;
  logic [3:0]  opc;
  logic [26:0] tbl [15];
  int          n_mismatch, n_compared, cycles;

  ispc_ctrl #(.OP_CYCLES(4), .OSC_CYCLES(16'h0001)) dut_u (
    .ref_clk, .rst_n, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(4'hf),
    .wb_ack_o(ack), .bootStrap(boot), .runFromLoader(rfl),
    .runIntoExternal(ext), .cpuHold(hold), .oscEnable(osc),
    .softResetReq(srst), .flashRegion(fReg), .flashAddr(fAddr),
    .flashWdata(wdOut), .flashRdata(rdIn), .flashOpCode(opc),
    .flashStrobe(strobe));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Expected fault from code residence, target and update enable
  function automatic logic expF(input logic fl, fx, fe,
      input logic [7:0] fc, input logic [15:0] fa);
    logic w;
    w = fc[3:0] != `ISPC_OP_READ;
    case (fc[7:6])
      `ISPC_REG_MAIN:   expF = fx || fa >= 16'h4000 || (w && !fl);
      `ISPC_REG_LOADER: expF = fx || fa >= 16'h0800 || (w && (fl || !fe));
      default: expF = fx || !fl ||
                      (fc[3:0] == `ISPC_OP_ERASE && fa != 16'h0000);
    endcase
    if (fc[3:0] == `ISPC_OP_ERASE && fa[6:0] != 7'h00) expF = 1'b1;
  endfunction

  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, v);
    cyc <= 1'b1;
    we <= w;
    adr <= {22'h0, i, 2'b00};
    wdat <= {24'h0, v};
    @(posedge ref_clk);
    while (!ack) @(posedge ref_clk);
    d = rdat;
    cyc <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic unl;
    bus(1'b1, `ISPC_IDX_TIMED, `ISPC_UNLOCK_1);
    bus(1'b1, `ISPC_IDX_TIMED, `ISPC_UNLOCK_2);
  endtask
  task automatic op(input logic ol, ox, input logic [7:0] oc,
      input logic [15:0] oa, input logic [7:0] ov);
    rfl <= ol;
    ext <= ox;
    bus(1'b1, `ISPC_IDX_CMD, oc);
    bus(1'b1, `ISPC_IDX_ADDRHI, oa[15:8]);
    bus(1'b1, `ISPC_IDX_ADDRLO, oa[7:0]);
    bus(1'b1, `ISPC_IDX_DATA, ov);
    holdSeen <= 1'b0;
    strobeSeen <= 1'b0;
    unl;
    bus(1'b1, `ISPC_IDX_TRIGGER, 8'h01);
    for (int k = 0; k < 40 && hold; k++) @(posedge ref_clk);
    chk(hold, 1'b0);
    ext <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (hold) holdSeen <= 1'b1;
    if (strobe) strobeSeen <= 1'b1;
    if (srst) srstSeen <= 1'b1;
    if (strobe) wdSeen <= wdOut;
    if (cycles == 8000) begin
      n_mismatch++;
      report_and_stop;
    end
  end

  initial begin
    {cyc, we, rfl, ext, holdSeen, strobeSeen, srstSeen} = '0;
    {adr, wdat, rdIn, wdSeen, cycles, n_mismatch, n_compared} = '0;
    boot = 1'b1;
    rng = 32'd15;
    tbl = '{{3'b000, 8'h21, 16'h0100}, {3'b000, 8'h61, 16'h0010},
            {3'b001, 8'h61, 16'h0010}, {3'b000, 8'h40, 16'h0010},
            {3'b000, 8'hc0, 16'h0001}, {3'b100, 8'h61, 16'h0010},
            {3'b100, 8'h00, 16'h4000}, {3'b110, 8'h00, 16'h0020},
            {3'b100, 8'he2, 16'h0000}, {3'b100, 8'he1, 16'h0002},
            {3'b100, 8'hc0, 16'h0003}, {3'b100, 8'h22, 16'h0080},
            {3'b100, 8'h22, 16'h0081}, {3'b100, 8'he2, 16'h0080},
            {3'b001, 8'h40, 16'h0800}};
    rst_n = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    bus(1'b0, `ISPC_IDX_CMD, 8'h00);
    chk(d[7:0], `ISPC_CMD_RESET);
    bus(1'b0, `ISPC_IDX_DATA, 8'h00);
    chk(d[7:0], 8'h00);
    bus(1'b0, 8'h10, 8'h00);
    chk(d, 32'h0);
    unl;
    bus(1'b1, `ISPC_IDX_TRIGGER, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk(holdSeen, 1'b0);
    unl;
    bus(1'b1, `ISPC_IDX_CHIPCTL, 8'h01);
    chk(osc, 1'b1);
    bus(1'b0, `ISPC_IDX_CHIPCTL, 8'h00);
    chk(d[1:0], 2'b11);
    bus(1'b1, `ISPC_IDX_TRIGGER, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk(holdSeen, 1'b0);
    unl;
    bus(1'b1, `ISPC_IDX_TRIGGER, 8'h00);
    repeat (4) @(posedge ref_clk);
    chk(holdSeen, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      rdIn <= rng[7:0];
      op(1'b1, 1'b0, i[0] ? 8'h21 : 8'h00, {2'b00, rng[21:8]}, rng[31:24]);
      chk(fAddr, {2'b00, rng[21:8]});
      chk(opc, {3'b000, i[0]});
      bus(1'b0, `ISPC_IDX_DATA, 8'h00);
      chk(i[0] ? wdSeen : d[7:0], i[0] ? rng[31:24] : rng[7:0]);
    end
    bus(1'b0, `ISPC_IDX_TRIGGER, 8'h00);
    chk(d[0], 1'b0);
    foreach (tbl[i]) begin
      {l, x, le, c, a} = tbl[i];
      unl;
      bus(1'b1, `ISPC_IDX_CHIPCTL, {2'b00, le, 5'b00001});
      op(l, x, c, a, 8'h5a);
      chk(fReg, c[7:6]);
      bus(1'b0, `ISPC_IDX_CHIPCTL, 8'h00);
      chk(d[6], expF(l, x, le, c, a));
      chk(strobeSeen, !expF(l, x, le, c, a));
    end
    op(1'b0, 1'b0, 8'h21, 16'h0100, 8'h00);
    op(1'b1, 1'b0, 8'h00, 16'h0000, 8'h00);
    bus(1'b0, `ISPC_IDX_CHIPCTL, 8'h00);
    chk(d[6], 1'b1);
    unl;
    bus(1'b1, `ISPC_IDX_CHIPCTL, 8'h00);
    bus(1'b0, `ISPC_IDX_CHIPCTL, 8'h00);
    chk(d[6], 1'b0);
    chk(osc, 1'b0);
    unl;
    bus(1'b1, `ISPC_IDX_CHIPCTL, 8'h80);
    bus(1'b0, `ISPC_IDX_CHIPCTL, 8'h00);
    chk(srstSeen, 1'b1);
    chk(d[1], 1'b0);
    report_and_stop;
  end
endmodule
